// ==== rtl/pim_pkg.sv ====
// Package with register map, field layouts and modes of the pin interrupt and pattern match block.
package pim_pkg;
    localparam int PIM_CH = 8;
    localparam int PIM_AW = 6;
    localparam int PIM_DW = 32;
    // Register word addresses (byte offsets on the core I/O bus).
    localparam logic [PIM_AW-1:0] PIM_ISEL = 6'h00;
    localparam logic [PIM_AW-1:0] PIM_IENR = 6'h04;
    localparam logic [PIM_AW-1:0] PIM_IENF = 6'h08;
    localparam logic [PIM_AW-1:0] PIM_RISE = 6'h0c;
    localparam logic [PIM_AW-1:0] PIM_FALL = 6'h10;
    localparam logic [PIM_AW-1:0] PIM_IST = 6'h14;
    localparam logic [PIM_AW-1:0] PIM_PMCTRL = 6'h18;
    localparam logic [PIM_AW-1:0] PIM_PMSRC = 6'h1c;
    localparam logic [PIM_AW-1:0] PIM_PMCFG = 6'h20;
    localparam logic [PIM_AW-1:0] PIM_PMST = 6'h24;
    localparam logic [PIM_AW-1:0] PIM_MASK = 6'h28;
    localparam logic [PIM_AW-1:0] PIM_PINS = 6'h2c;
    // Pattern match control fields.
    localparam int PIM_PMCTRL_SEL = 0;
    localparam int PIM_PMCTRL_EV = 1;
    // Each slice has a 3-bit condition in the config word and a 3-bit input select in the source word.
    localparam int PIM_CW = 3;
    localparam logic [PIM_DW-1:0] PIM_ZERO = 32'h0000_0000;
    // Slice conditions.
    typedef enum logic [2:0] {
        PIM_C_TRUE, PIM_C_RISE, PIM_C_FALL, PIM_C_EDGE,
        PIM_C_HIGH, PIM_C_LOW, PIM_C_ENDCHAIN, PIM_C_NEVER
    } pim_cond_t;
endpackage

// ==== rtl/pim_slice.sv ====
// One pattern match slice: tests a selected input for a level or a transition.
`timescale 1ns/1ns
module pim_slice (
    input wire logic [pim_pkg::PIM_CH-1:0] cur,
    input wire logic [pim_pkg::PIM_CH-1:0] prev,
    input wire logic [pim_pkg::PIM_CW-1:0] src,
    input wire pim_pkg::pim_cond_t cond,
    output logic hit,
    output logic ends_term
);
    import pim_pkg::*;
    logic c;
    logic p;
    assign c = cur[src];
    assign p = prev[src];
    assign ends_term = (cond == PIM_C_ENDCHAIN);
    always_comb begin
        unique case (cond)
            PIM_C_TRUE: hit = 1'b1;
            PIM_C_RISE: hit = c & ~p;
            PIM_C_FALL: hit = ~c & p;
            PIM_C_EDGE: hit = c ^ p;
            PIM_C_HIGH: hit = c;
            PIM_C_LOW: hit = ~c;
            PIM_C_ENDCHAIN: hit = c;
            PIM_C_NEVER: hit = 1'b0;
        endcase
    end
endmodule

// ==== rtl/pim_top.sv ====
// Pin interrupt and pattern match engine with register port and per-channel request outputs.
//
// Overview of operation
// - Eight selected pin inputs each act as an edge or level interrupt source.
// - Each channel drives its own separate interrupt request line while pattern match mode is off; in that mode the lines carry product terms.
// - Edge channels trigger on rising, falling, or both edges.
// - Level channels are programmable high-active or low-active.
// - Pin request detection works without the processor and drives the wake output while pattern match mode is off.
// - Up to eight selected inputs form one boolean sum-of-minterms expression.
// - Each term slice tests its input for a level or a transition.
// - Every product term raises its own dedicated request when true.
// - When enabled, any match holds the core event notify output high for as long as it lasts.
// - The event notify signal is also driven to a pin output.
// - Pattern match requests never contribute to the wake output.
// - Inputs are sampled regardless of pin function; selection is external.
// - Registers answer single-cycle reads and writes on the I/O port.
`timescale 1ns/1ns
module pim_top #(
    parameter int N = pim_pkg::PIM_CH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [N-1:0] pin_in,
    input wire logic [pim_pkg::PIM_AW-1:0] reg_addr,
    input wire logic [pim_pkg::PIM_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pim_pkg::PIM_DW-1:0] reg_rdata,
    output logic [N-1:0] pin_irq,
    output logic wake_req,
    output logic core_event_notify,
    output logic event_pin_out,
    output logic irq
);
    import pim_pkg::*;

    // Pins are chosen by the system_config_block; this block sees them whatever owns the pad.
    logic [N-1:0] cur_r;
    logic [N-1:0] prev_r;
    logic [N-1:0] isel_r;
    logic [N-1:0] ienr_r;
    logic [N-1:0] ienf_r;
    logic [N-1:0] rise_r;
    logic [N-1:0] fall_r;
    logic [N-1:0] ist_r;
    logic [N-1:0] pmst_r;
    logic [N-1:0] mask_r;
    logic [1:0] pmctrl_r;
    logic [N*PIM_CW-1:0] pmsrc_r;
    logic [N*PIM_CW-1:0] pmcfg_r;
    logic [N-1:0] pin_req;
    logic [N-1:0] term_hit;
    logic [N-1:0] slice_hit;
    logic [N-1:0] slice_end;
    logic [N-1:0] rise_ev;
    logic [N-1:0] fall_ev;
    logic [N-1:0] pm_req;
    logic any_match;
    logic [PIM_DW-1:0] rdata_nxt;

    function automatic logic wr_hit(input logic [PIM_AW-1:0] a, input logic [PIM_AW-1:0] off);
        wr_hit = reg_wr && (a == off);
    endfunction

    function automatic logic [PIM_DW-1:0] widen(input logic [N-1:0] v);
        widen = PIM_ZERO;
        widen[N-1:0] = v;
    endfunction

    // Slice words hold one field per slice; bits above the last slice read back as zero.
    function automatic logic [PIM_DW-1:0] widen_cfg(input logic [N*PIM_CW-1:0] v);
        widen_cfg = PIM_ZERO;
        widen_cfg[N*PIM_CW-1:0] = v;
    endfunction

    function automatic logic [N-1:0] clr_bits(input logic [PIM_AW-1:0] off);
        clr_bits = wr_hit(reg_addr, off) ? reg_wdata[N-1:0] : '0;
    endfunction

    // Input capture and previous sample for transition detection.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Tracking the pins through reset keeps a pin that idles high from posing as a fresh edge.
            cur_r <= pin_in;
            prev_r <= pin_in;
        end else begin
            cur_r <= pin_in;
            prev_r <= cur_r;
        end
    end

    assign rise_ev = cur_r & ~prev_r;
    assign fall_ev = ~cur_r & prev_r;

    // Configuration registers, one process each; writes to any other address leave them alone.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            isel_r <= '0;
        end else if (wr_hit(reg_addr, PIM_ISEL)) begin
            isel_r <= reg_wdata[N-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ienr_r <= '0;
        end else if (wr_hit(reg_addr, PIM_IENR)) begin
            ienr_r <= reg_wdata[N-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ienf_r <= '0;
        end else if (wr_hit(reg_addr, PIM_IENF)) begin
            ienf_r <= reg_wdata[N-1:0];
        end
    end

    // Switching mode while inputs are active can leave stale status bits; clear status after a switch.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmctrl_r <= '0;
        end else if (wr_hit(reg_addr, PIM_PMCTRL)) begin
            pmctrl_r <= reg_wdata[PIM_PMCTRL_EV:PIM_PMCTRL_SEL];
        end
    end

    // Only the slice fields are stored, so the unused top bits cost no flops.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmsrc_r <= '0;
        end else if (wr_hit(reg_addr, PIM_PMSRC)) begin
            pmsrc_r <= reg_wdata[N*PIM_CW-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmcfg_r <= '0;
        end else if (wr_hit(reg_addr, PIM_PMCFG)) begin
            pmcfg_r <= reg_wdata[N*PIM_CW-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_r <= '0;
        end else if (wr_hit(reg_addr, PIM_MASK)) begin
            mask_r <= reg_wdata[N-1:0];
        end
    end

    // Sticky edge flags; a new edge in the clearing cycle wins over the clear.
    // Every input latches its edges whatever its enables, so software can poll an input that requests nothing.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rise_r <= '0;
        end else begin
            rise_r <= (rise_r & ~clr_bits(PIM_RISE)) | rise_ev;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fall_r <= '0;
        end else begin
            fall_r <= (fall_r & ~clr_bits(PIM_FALL)) | fall_ev;
        end
    end

    // In level mode the fall enable selects the polarity: one is low-active.
    // An edge channel keeps requesting until software clears its flag.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (isel_r[i]) begin
                pin_req[i] = ienf_r[i] ? ~cur_r[i] : (ienr_r[i] & cur_r[i]);
            end else begin
                pin_req[i] = (ienr_r[i] & rise_r[i]) | (ienf_r[i] & fall_r[i]);
            end
        end
    end

    // Pattern match slices; a term runs from after one chain end up to the next.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_slice
            pim_slice u_slice (
                .cur(cur_r),
                .prev(prev_r),
                .src(pmsrc_r[g*PIM_CW +: PIM_CW]),
                .cond(pim_cond_t'(pmcfg_r[g*PIM_CW +: PIM_CW])),
                .hit(slice_hit[g]),
                .ends_term(slice_end[g])
            );
        end
    endgenerate

    // Product terms: running AND reset after each end marker; the last slice always ends a term.
    always_comb begin
        logic acc;
        acc = 1'b1;
        term_hit = '0;
        for (int i = 0; i < N; i++) begin
            acc = acc & slice_hit[i];
            if (slice_end[i] || i == N-1) begin
                term_hit[i] = acc;
                acc = 1'b1;
            end
        end
    end

    assign pm_req = pmctrl_r[PIM_PMCTRL_SEL] ? term_hit : '0;
    assign any_match = |pm_req;

    // Pin and pattern match status bits, sticky, set wins over the write-one clear.
    // A level request still present when software clears its bit sets it again, so remove the cause first.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ist_r <= '0;
        end else begin
            ist_r <= (ist_r & ~clr_bits(PIM_IST)) | pin_req;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmst_r <= '0;
        end else begin
            pmst_r <= (pmst_r & ~clr_bits(PIM_PMST)) | pm_req;
        end
    end

    // Request outputs: pin channel or pattern term per line, depending on mode.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_irq <= '0;
        end else begin
            pin_irq <= pmctrl_r[PIM_PMCTRL_SEL] ? pm_req : pin_req;
        end
    end

    // Wake uses only the pin flops and needs no processor activity; pattern terms never reach it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= pmctrl_r[PIM_PMCTRL_SEL] ? 1'b0 : |pin_req;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_event_notify <= 1'b0;
        end else begin
            core_event_notify <= pmctrl_r[PIM_PMCTRL_EV] & any_match;
        end
    end

    // A flop of its own for the pad, so pad routing does not load the core event line.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_pin_out <= 1'b0;
        end else begin
            event_pin_out <= pmctrl_r[PIM_PMCTRL_EV] & any_match;
        end
    end

    // Status, not live requests, feeds the interrupt, so a one-cycle term pulse is not lost.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((ist_r | pmst_r) & mask_r);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        unique case (reg_addr)
            PIM_ISEL: rdata_nxt = widen(isel_r);
            PIM_IENR: rdata_nxt = widen(ienr_r);
            PIM_IENF: rdata_nxt = widen(ienf_r);
            PIM_RISE: rdata_nxt = widen(rise_r);
            PIM_FALL: rdata_nxt = widen(fall_r);
            PIM_IST: rdata_nxt = widen(ist_r);
            PIM_PMCTRL: rdata_nxt = {30'h0000_0000, pmctrl_r};
            PIM_PMSRC: rdata_nxt = widen_cfg(pmsrc_r);
            PIM_PMCFG: rdata_nxt = widen_cfg(pmcfg_r);
            PIM_PMST: rdata_nxt = widen(pmst_r);
            PIM_MASK: rdata_nxt = widen(mask_r);
            PIM_PINS: rdata_nxt = widen(cur_r);
            default: rdata_nxt = PIM_ZERO;
        endcase
    end

    // Read data is zero outside the answer cycle, so several slaves can share an OR-ed return path.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= PIM_ZERO;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : PIM_ZERO;
        end
    end
endmodule

// ==== sim/pim_checker.sv ====
// Port checker for the pin interrupt block.
`timescale 1ns/1ns
module pim_checker #(
    parameter int N = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [pim_pkg::PIM_AW-1:0] reg_addr,
    input wire logic [pim_pkg::PIM_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pim_pkg::PIM_DW-1:0] reg_rdata,
    input wire logic [N-1:0] pin_irq,
    input wire logic wake_req,
    input wire logic core_event_notify,
    input wire logic event_pin_out,
    input wire logic irq
);
    import pim_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic pm_r, ev_r, mz_r;
    logic [1:0] pm_c, ev_c, mz_c;
    // Counters wait three cycles so a write and the output flop have landed.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pm_r <= 1'b0;
            ev_r <= 1'b0;
        end else if (reg_wr && reg_addr == PIM_PMCTRL) begin
            pm_r <= reg_wdata[PIM_PMCTRL_SEL];
            ev_r <= reg_wdata[PIM_PMCTRL_EV];
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) mz_r <= 1'b1;
        else if (reg_wr && reg_addr == PIM_MASK) mz_r <= (reg_wdata[N-1:0] == '0);
    end
    always_ff @(posedge core_clk) begin
        pm_c <= (rst || !pm_r) ? 2'h0 : (pm_c == 2'h3 ? pm_c : pm_c + 2'h1);
        ev_c <= (rst || ev_r) ? 2'h0 : (ev_c == 2'h3 ? ev_c : ev_c + 2'h1);
        mz_c <= (rst || !mz_r) ? 2'h0 : (mz_c == 2'h3 ? mz_c : mz_c + 2'h1);
    end
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == PIM_ZERO)
        else $error("read data not zero outside answer cycle");
    a_rdata_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:24] == 8'h00)
        else $error("read data upper byte not zero");
    a_reset_quiet: assert property ($past(rst) |-> pin_irq == '0 && !irq && !wake_req && !core_event_notify)
        else $error("outputs active right after reset");
    a_event_pin_mirror: assert property (event_pin_out == core_event_notify)
        else $error("event pin differs from core event");
    a_wake_has_request: assert property (wake_req |-> |pin_irq)
        else $error("wake without any pin request");
    a_pattern_no_wake: assert property (pm_c == 2'h3 |-> !wake_req)
        else $error("wake raised in pattern mode");
    a_masked_no_irq: assert property (mz_c == 2'h3 |-> !irq)
        else $error("interrupt with all sources masked");
    a_event_off_quiet: assert property (ev_c == 2'h3 |-> !core_event_notify)
        else $error("event notify while disabled");
endmodule
bind pim_top pim_checker #(.N(N)) u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_irq(pin_irq),
    .wake_req(wake_req), .core_event_notify(core_event_notify), .event_pin_out(event_pin_out), .irq(irq));

// ==== sim/pim_core_model.sv ====
// Model of the core interrupt controller and event input.
`timescale 1ns/1ns
module pim_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] pin_irq,
    input wire logic core_event_notify,
    output logic [7:0] pend,
    output int ev_count
);
    // Each line pends its own vector; a shared line would hide which channel fired.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend <= 8'h00;
            ev_count <= 0;
        end else begin
            pend <= pend | pin_irq;
            ev_count <= ev_count + int'(core_event_notify);
        end
    end
endmodule

// ==== sim/pim_top_tb.sv ====
// Self-checking testbench of the pin interrupt and pattern match block.
`timescale 1ns/1ns
module pim_top_tb;
    import pim_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] pin_in = 8'h06;
    logic [PIM_AW-1:0] reg_addr = '0;
    logic [PIM_DW-1:0] reg_wdata = PIM_ZERO;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [PIM_DW-1:0] reg_rdata;
    logic [7:0] pin_irq, pend;
    logic wake_req, core_event_notify, event_pin_out, irq;
    int ev_count, ev0;
    int err_total = 0;
    int checks = 0;
    pim_top #(.N(8)) DUT (.core_clk(core_clk), .rst(rst), .pin_in(pin_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_irq(pin_irq),
        .wake_req(wake_req), .core_event_notify(core_event_notify), .event_pin_out(event_pin_out), .irq(irq));
    pim_core_model u_core (.core_clk(core_clk), .rst(rst), .pin_irq(pin_irq),
        .core_event_notify(core_event_notify), .pend(pend), .ev_count(ev_count));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [PIM_AW-1:0] a, input logic [PIM_DW-1:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [PIM_AW-1:0] a, input logic [PIM_DW-1:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Pin changes need three edges to reach the request outputs; five leaves margin.
    task automatic pins(input logic [7:0] v);
        @(posedge core_clk);
        pin_in <= v;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rc(PIM_MASK, PIM_ZERO);
        wr(PIM_MASK, 32'h0000_00ff);
        rc(PIM_MASK, 32'h0000_00ff);
        rc(6'h30, PIM_ZERO);
        wr(PIM_IENR, 32'h0000_0011);
        wr(PIM_IENF, 32'h0000_0016);
        wr(PIM_ISEL, 32'h0000_0004);
        pins(8'h07);
        chk(pin_irq, 8'h01);
        chk({wake_req, irq}, 2'b11);
        rc(PIM_RISE, 32'h0000_0001);
        pins(8'h05);
        rc(PIM_FALL, 32'h0000_0002);
        pins(8'h01);
        chk(pin_irq, 8'h07);
        pins(8'h05);
        chk(pin_irq, 8'h03);
        chk(pend, 8'h07);
        wr(PIM_RISE, 32'h0000_00ff);
        wr(PIM_FALL, 32'h0000_00ff);
        wr(PIM_IST, 32'h0000_00ff);
        pins(8'h05);
        chk({pin_irq, wake_req, irq}, 10'h000);
        pins(8'h14);
        pins(8'h04);
        chk(pin_irq, 8'h10);
        // Flags latch every edge whatever the enables: input 0 fell on the way to 8'h14.
        rc(PIM_FALL, 32'h0000_0011);
        wr(PIM_RISE, 32'h0000_00ff);
        wr(PIM_FALL, 32'h0000_00ff);
        wr(PIM_IST, 32'h0000_00ff);
        wr(PIM_PMSRC, 32'h0000_0003);
        wr(PIM_PMCFG, 32'h00ff_fffe);
        wr(PIM_PMCTRL, 32'h0000_0003);
        ev0 = ev_count;
        pins(8'h0c);
        chk({pin_irq, wake_req, core_event_notify, event_pin_out}, {8'h01, 3'b011});
        pins(8'h04);
        chk(pin_irq, 8'h00);
        chk(ev_count > ev0 + 2, 1'b1);
        rc(PIM_PMST, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(PIM_PMCTRL, 32'h0000_0001);
        wr(PIM_MASK, PIM_ZERO);
        pins(8'h0c);
        chk({pin_irq, core_event_notify, irq}, {8'h01, 2'b00});
        // Term on slice 1: rise of input 3 while input 2 is high; top byte of the config word is dropped.
        wr(PIM_PMSRC, 32'h0000_0013);
        wr(PIM_PMCFG, 32'hffff_fff1);
        rc(PIM_PMCFG, 32'h00ff_fff1);
        wr(PIM_PMST, 32'h0000_00ff);
        pins(8'h04);
        pins(8'h0c);
        rc(PIM_PMST, 32'h0000_0002);
        rc(PIM_PINS, 32'h0000_000c);
        conclude();
    end
endmodule
